// ==== gpio_port_defs.vh ====
/*
 * constants for the eight-bit general-purpose port: register offsets,
 * field positions and reset values.
 * assumes: included by bare name from the port's design files.
 */
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// ----------------------------------------
// register byte offsets on apb
// ----------------------------------------
`define OFS_OUTPUT_LATCH 12'h000
`define OFS_DIRECTION 12'h004
`define OFS_PULLUP_ENABLE 12'h008
`define OFS_STANDBY_CONTROL 12'h00c
`define OFS_IRQ_ENABLES 12'h010
`define OFS_PIN_STATUS 12'h014

// ----------------------------------------
// fields
// ----------------------------------------
`define STBY_FLOAT_BIT 0
`define STBY_MODE_BIT 1
`define IRQ_CTRL_PIN4_BIT 0
`define IRQ_CTRL_PIN6_BIT 1
`define IRQ_SEL_PIN4_BIT 2
`define IRQ_SEL_PIN6_BIT 3
`define PIN_FOUR 4
`define PIN_SIX 6
`define PIN_TWO 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_OUTPUT_LATCH 8'h00
`define RST_DIRECTION 8'h00
`define RST_PULLUP_ENABLE 8'h00
`define RST_STANDBY_CONTROL 2'h0
`define RST_IRQ_ENABLES 4'h0

`endif

// ==== pin_input_sync.v ====
/*
 * two-stage synchroniser for a vector of pin inputs.
 * assumes: inputs are asynchronous to i_clk; one clock domain.
 */
`default_nettype none

module pin_input_sync #(
   parameter WIDTH = 8
) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // ----------------------------------------
   // first stage is read only by the second
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

`default_nettype wire

// ==== gpio_port.v ====
/*
 * eight-bit general-purpose port with apb register access: output latch,
 * direction, pull-up enable, standby pin float and pin sharing with
 * on-chip peripherals.
 * assumes: apb master on i_clk; pads resolve o_pin_out/o_pin_oe and the
 * pull-up enables; peripheral outputs arrive on the same clock.
 */
`default_nettype none
`include "gpio_port_defs.vh"

// Overview of operation
// - direction one drives pin from latch
// - latch write appears on output pins
// - direction zero: latch written, pin undriven
// - input read gives pin, rmw gives latch
// - port output read returns latch value
// - peripheral enable drives pin; reads as input
// - peripheral input pin reads pin level
// - reset clears direction: all inputs
// - float in standby: hi-z, input forced low
// - pins four, six stay live for irq
// - no float: standby holds pin states
// - pull-up bit one connects pull-up
// - driven low output drops pull-up
// - bit n controls pin n
// - pin two pull-up bit has no effect
// - open-drain output high leaves hi-z
module gpio_port #(
   parameter [7:0] OPEN_DRAIN_MASK = 8'h00,
   parameter [7:0] PULLUP_PRESENT = 8'hfb
) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire o_pready,
   output reg [31:0] o_prdata,
   output wire o_pslverr,
   input wire i_read_modify_write,
   input wire i_standby_active,
   input wire [7:0] i_periph_oe,
   input wire [7:0] i_periph_out,
   input wire [7:0] i_pin_in,
   output reg [7:0] o_pin_out,
   output reg [7:0] o_pin_oe,
   output reg [7:0] o_pullup_on,
   output wire [7:0] o_pin_to_periph
);

   reg [7:0] port_output_latch_reg;
   reg [7:0] port_direction_reg;
   reg [7:0] port_pullup_enable_reg;
   reg [1:0] standby_control_reg;
   reg [3:0] irq_enables_reg;
   reg [7:0] frozen_out_reg;
   reg [7:0] frozen_oe_reg;
   reg standby_seen_reg;
   wire [7:0] pin_sync;
   wire [7:0] live_out;
   wire [7:0] live_oe;
   wire standby_now;
   wire float_now;
   wire [7:0] input_keep;
   wire [7:0] pin_gated;
   wire apb_write;
   wire apb_read;
   reg [7:0] port_read;
   reg addr_ok;
   reg [7:0] pin_out_next;
   reg [7:0] pin_oe_next;
   reg [7:0] pullup_next;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // rmw reads take the latch, other reads the latch on port-driven outputs and the pin level elsewhere
   function [7:0] port_read_value;
      input [7:0] latch;
      input [7:0] pin;
      input [7:0] dir;
      input [7:0] poe;
      input read_modify_write;
      begin
         if (read_modify_write)
            port_read_value = latch;
         else
            port_read_value = (latch & dir & ~poe) | (pin & ~(dir & ~poe));
      end
   endfunction

   function addr_known;
      input [11:0] a;
      begin
         addr_known = (a == `OFS_OUTPUT_LATCH) || (a == `OFS_DIRECTION) ||
            (a == `OFS_PULLUP_ENABLE) || (a == `OFS_STANDBY_CONTROL) ||
            (a == `OFS_IRQ_ENABLES) || (a == `OFS_PIN_STATUS);
      end
   endfunction

   // a pin driven low never keeps its pull-up; absent pull-ups stay off
   function [7:0] pullup_value;
      input [7:0] enable;
      input [7:0] oe;
      input [7:0] out;
      begin
         pullup_value = enable & PULLUP_PRESENT & ~(oe & ~out);
      end
   endfunction

   // an interrupt pin stays open only with both enables set
   function irq_pin_open;
      input ctrl_en;
      input sel_en;
      begin
         irq_pin_open = ctrl_en & sel_en;
      end
   endfunction

   // register read mux; unmapped offsets read as zero
   function [31:0] reg_read_value;
      input [11:0] a;
      input [7:0] port_val;
      input [7:0] dir;
      input [7:0] pull;
      input [1:0] stby;
      input [3:0] irq;
      input [7:0] pins;
      begin
         case (a)
            `OFS_OUTPUT_LATCH: reg_read_value = {24'h00_0000, port_val};
            `OFS_DIRECTION: reg_read_value = {24'h00_0000, dir};
            `OFS_PULLUP_ENABLE: reg_read_value = {24'h00_0000, pull};
            `OFS_STANDBY_CONTROL: reg_read_value = {30'h0000_0000, stby};
            `OFS_IRQ_ENABLES: reg_read_value = {28'h000_0000, irq};
            `OFS_PIN_STATUS: reg_read_value = {24'h00_0000, pins};
            default: reg_read_value = 32'h0000_0000;
         endcase
      end
   endfunction

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   pin_input_sync #(
      .WIDTH(8)
   ) u_pin_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_pin_in),
      .o_sync(pin_sync)
   );

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // zero wait states; unmapped addresses answer with pslverr
   assign o_pready = 1'b1;
   assign apb_write = i_psel & i_penable & i_pwrite;
   assign apb_read = i_psel & i_penable & ~i_pwrite;
   assign o_pslverr = i_psel & i_penable & ~addr_ok;

   always @* begin
      addr_ok = addr_known(i_paddr);
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         port_output_latch_reg <= `RST_OUTPUT_LATCH;
         port_direction_reg <= `RST_DIRECTION;
         port_pullup_enable_reg <= `RST_PULLUP_ENABLE;
         standby_control_reg <= `RST_STANDBY_CONTROL;
         irq_enables_reg <= `RST_IRQ_ENABLES;
      end else if (apb_write) begin
         case (i_paddr)
            `OFS_OUTPUT_LATCH: begin
               port_output_latch_reg <= i_pwdata[7:0];
            end
            `OFS_DIRECTION: begin
               port_direction_reg <= i_pwdata[7:0];
            end
            `OFS_PULLUP_ENABLE: begin
               port_pullup_enable_reg <= i_pwdata[7:0];
            end
            `OFS_STANDBY_CONTROL: begin
               standby_control_reg <= i_pwdata[1:0];
            end
            `OFS_IRQ_ENABLES: begin
               irq_enables_reg <= i_pwdata[3:0];
            end
            default: begin
               port_output_latch_reg <= port_output_latch_reg;
            end
         endcase
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   // blocked pins read low while floated, like the peripheral path
   always @* begin
      port_read = port_read_value(port_output_latch_reg, pin_gated, port_direction_reg,
         i_periph_oe, i_read_modify_write);
   end

   // read data registered at the setup edge as a data output
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel & ~i_penable & ~i_pwrite) begin
         o_prdata <= reg_read_value(i_paddr, port_read, port_direction_reg,
            port_pullup_enable_reg, standby_control_reg, irq_enables_reg, pin_gated);
      end
   end

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   // peripheral output takes the pin when enabled; software must have
   // turned it off before port use, otherwise it keeps the pin
   assign live_out = (i_periph_oe & i_periph_out) |
      (~i_periph_oe & port_output_latch_reg);
   assign live_oe = (i_periph_oe | port_direction_reg) &
      ~(OPEN_DRAIN_MASK & live_out);

   // ----------------------------------------
   // standby state
   // ----------------------------------------
   // software standby and the core's standby level act alike
   assign standby_now = i_standby_active | standby_control_reg[`STBY_MODE_BIT];
   assign float_now = standby_now & standby_control_reg[`STBY_FLOAT_BIT];

   // ----------------------------------------
   // standby freeze
   // ----------------------------------------
   // freeze levels on standby entry so they hold while standing by
   // limitation: latch writes in standby reach the pins only after wake-up
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         frozen_out_reg <= 8'h00;
         frozen_oe_reg <= 8'h00;
         standby_seen_reg <= 1'b0;
      end else begin
         standby_seen_reg <= standby_now;
         if (~standby_seen_reg) begin
            frozen_out_reg <= live_out;
            frozen_oe_reg <= live_oe;
         end
      end
   end

   // ----------------------------------------
   // pin registers
   // ----------------------------------------
   always @* begin
      pin_out_next = live_out;
      pin_oe_next = live_oe;
      pullup_next = pullup_value(port_pullup_enable_reg, live_oe, live_out);
      if (float_now) begin
         pin_out_next = 8'h00;
         pin_oe_next = 8'h00;
         // floated pins keep their pull-ups under register control
         pullup_next = pullup_value(port_pullup_enable_reg, 8'h00, 8'h00);
      end else if (standby_now & standby_seen_reg) begin
         pin_out_next = frozen_out_reg;
         pin_oe_next = frozen_oe_reg;
         pullup_next = pullup_value(port_pullup_enable_reg, frozen_oe_reg, frozen_out_reg);
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_pin_out <= 8'h00;
         o_pin_oe <= 8'h00;
         o_pullup_on <= 8'h00;
      end else begin
         o_pin_out <= pin_out_next;
         o_pin_oe <= pin_oe_next;
         o_pullup_on <= pullup_next;
      end
   end

   // ----------------------------------------
   // input path to peripherals
   // ----------------------------------------
   // pins four and six stay open for wake-up interrupts
   assign input_keep[`PIN_FOUR] = irq_pin_open(irq_enables_reg[`IRQ_CTRL_PIN4_BIT],
      irq_enables_reg[`IRQ_SEL_PIN4_BIT]);
   assign input_keep[`PIN_SIX] = irq_pin_open(irq_enables_reg[`IRQ_CTRL_PIN6_BIT],
      irq_enables_reg[`IRQ_SEL_PIN6_BIT]);
   assign input_keep[3:0] = 4'h0;
   assign input_keep[5] = 1'b0;
   assign input_keep[7] = 1'b0;
   assign pin_gated = float_now ? (pin_sync & input_keep) : pin_sync;
   assign o_pin_to_periph = pin_gated;

endmodule

`default_nettype wire

// ==== gpio_pad_model.sv ====
/* pad model: settles each pin from the port, a far-side driver and the pull-up.
   assumes: the far side drives only pins that the port leaves undriven. */
`default_nettype none
module gpio_pad_model (
   input wire logic i_clk,
   input wire logic [7:0] i_pin_out,
   input wire logic [7:0] i_pin_oe,
   input wire logic [7:0] i_pullup_on,
   input wire logic [7:0] i_ext_val,
   input wire logic [7:0] i_ext_oe,
   output logic [7:0] o_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wobble_reg = 8'h55;
   // ------------
   // pin levels
   // ------------
   // bare pins wander so a stale level never passes as a match
   always @(posedge i_clk) wobble_reg <= ~wobble_reg;
   assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_oe & i_ext_val)
      | (~i_pin_oe & ~i_ext_oe & (i_pullup_on | wobble_reg));
endmodule
`default_nettype wire

// ==== gpio_port_props.sv ====
/* assertions on the port's pins, with shadows of the written registers.
   assumes: apb writes land at the access edge; synchronous reset. */
`default_nettype none
module gpio_port_props #(parameter [7:0] PULLUP_PRESENT = 8'hfb,
   parameter [7:0] OPEN_DRAIN_MASK = 8'h00) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire logic i_read_modify_write,
   input wire logic i_standby_active,
   input wire logic [7:0] i_periph_oe,
   input wire logic [7:0] i_periph_out,
   input wire logic [7:0] i_pin_in,
   input wire logic [7:0] o_pin_out,
   input wire logic [7:0] o_pin_oe,
   input wire logic [7:0] o_pullup_on,
   input wire logic [7:0] o_pin_to_periph
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lat_reg, dir_reg, pul_reg, keep;
   logic [3:0] irq_reg;
   logic flt_reg, stb_reg, sb;
   // -----------------
   // register shadows
   // -----------------
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         {lat_reg, dir_reg, pul_reg, irq_reg, stb_reg, flt_reg} <= '0;
      end else if (i_psel && i_penable && i_pwrite) begin
         case (i_paddr)
            12'h000: lat_reg <= i_pwdata[7:0];
            12'h004: dir_reg <= i_pwdata[7:0];
            12'h008: pul_reg <= i_pwdata[7:0];
            12'h00c: {stb_reg, flt_reg} <= i_pwdata[1:0];
            12'h010: irq_reg <= i_pwdata[3:0];
            default: ;
         endcase
      end
   end
   assign sb = i_standby_active | stb_reg;
   assign keep = {1'b0, irq_reg[1] & irq_reg[3], 1'b0, irq_reg[0] & irq_reg[2], 4'h0};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_reset_dir: assert property ($fell(i_sys_rst) |-> o_pin_oe == 8'h00)
      else $error("pin driven after reset");
   a_port_drive: assert property ((!sb && i_periph_oe == 8'h00 && $stable(dir_reg)
      && $stable(lat_reg))[*3] |-> o_pin_oe == (dir_reg & ~(OPEN_DRAIN_MASK & lat_reg))
      && ((o_pin_out ^ lat_reg) & dir_reg) == 8'h00)
      else $error("port pins differ from latch");
   a_periph_drive: assert property ((!sb && $stable(i_periph_oe) && $stable(i_periph_out))[*3]
      |-> (o_pin_oe & i_periph_oe) == (i_periph_oe & ~(OPEN_DRAIN_MASK & i_periph_out))
      && ((o_pin_out ^ i_periph_out) & i_periph_oe) == 8'h00)
      else $error("peripheral pins not driven");
   a_float_hiz: assert property ((sb && flt_reg)[*3] |-> o_pin_oe == 8'h00)
      else $error("pin driven while floated");
   a_float_block: assert property ((sb && flt_reg)[*3] |-> (o_pin_to_periph & ~keep) == 8'h00)
      else $error("input not blocked");
   a_irq_live: assert property ((sb && flt_reg && keep[4] && i_pin_in[4])[*4]
      |-> o_pin_to_periph[4]) else $error("irq input blocked");
   a_hold_levels: assert property ((sb && !flt_reg)[*2] |=> $stable(o_pin_out) && $stable(o_pin_oe))
      else $error("levels moved in standby");
   a_pullup_map: assert property ((!sb && $stable(pul_reg) && $stable(o_pin_oe)
      && $stable(o_pin_out))[*3] |-> o_pullup_on == (pul_reg & PULLUP_PRESENT & ~(o_pin_oe & ~o_pin_out)))
      else $error("pull-up mismatch");
   a_low_no_pull: assert property ((o_pullup_on & o_pin_oe & ~o_pin_out) == 8'h00)
      else $error("pull-up on low pin");
endmodule
bind gpio_port gpio_port_props #(.PULLUP_PRESENT(PULLUP_PRESENT),
   .OPEN_DRAIN_MASK(OPEN_DRAIN_MASK)) props (.i_clk, .i_sys_rst,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr,
   .i_read_modify_write, .i_standby_active, .i_periph_oe, .i_periph_out, .i_pin_in,
   .o_pin_out, .o_pin_oe, .o_pullup_on, .o_pin_to_periph);
`default_nettype wire

// ==== test_eight_bit_gpio_port.sv ====
/* self-checking bench for the port: apb tasks, pad model, one task per scenario, pull-up and address checks inline.
   assumes: zero-wait apb, registered pins, pin reads two edges late. */
`default_nettype none
module test_eight_bit_gpio_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic read_modify_write = 1'b0, sb = 1'b0, pready, pslverr, rerr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [7:0] poe = 8'h00, pout = 8'h00, ext_val = 8'h00, ext_oe = 8'hff;
   logic [7:0] pin_out, pin_oe, pull_on, to_periph, level;
   int errors = 0, samples_checked = 0;
   gpio_port #(.OPEN_DRAIN_MASK(8'h20)) dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
      .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .i_read_modify_write(read_modify_write),
      .i_standby_active(sb), .i_periph_oe(poe), .i_periph_out(pout), .i_pin_in(level),
      .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pullup_on(pull_on),
      .o_pin_to_periph(to_periph));
   gpio_pad_model pads (.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
      .i_pullup_on(pull_on), .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(level));
   // --------------
   // common tasks
   // --------------
   initial forever #2.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // -----------
   // scenarios
   // -----------
   task automatic t_in();
      ext_oe <= 8'hf0; // far side leaves port-driven pins alone
      ext_val <= 8'h90;
      bus(1'b1, 12'h004, 32'h0f);
      bus(1'b1, 12'h000, 32'h3c);
      repeat (4) @(posedge clk);
      chk(pin_oe, 8'h0f);
      chk(pin_out & 8'h0f, 8'h0c);
      rd(12'h000, 32'h9c);
      read_modify_write <= 1'b1;
      rd(12'h000, 32'h3c);
      read_modify_write <= 1'b0;
   endtask
   task automatic t_periph();
      bus(1'b1, 12'h004, 32'h00);
      ext_oe <= 8'h7e;
      ext_val <= 8'h00;
      poe <= 8'h81;
      pout <= 8'h80;
      repeat (4) @(posedge clk);
      chk(pin_oe & 8'h81, 8'h81);
      chk(pin_out & 8'h81, 8'h80);
      rd(12'h000, 32'h80);
      chk(to_periph, 8'h80);
      poe <= 8'h00; // peripheral off before port use
      ext_oe <= 8'hf0;
   endtask
   task automatic t_float();
      bus(1'b1, 12'h004, 32'h00);
      ext_oe <= 8'hff;
      ext_val <= 8'h50;
      bus(1'b1, 12'h010, 32'h5);
      bus(1'b1, 12'h00c, 32'h1);
      sb <= 1'b1;
      repeat (4) @(posedge clk);
      chk(pin_oe, 8'h00);
      chk(to_periph, 8'h10);
      bus(1'b1, 12'h010, 32'ha);
      repeat (2) @(posedge clk);
      chk(to_periph, 8'h40);
      sb <= 1'b0;
      repeat (4) @(posedge clk);
      chk(to_periph, 8'h50);
   endtask
   task automatic t_hold();
      bus(1'b1, 12'h00c, 32'h0);
      ext_oe <= 8'h00;
      bus(1'b1, 12'h004, 32'hff);
      bus(1'b1, 12'h000, 32'h5a);
      bus(1'b1, 12'h00c, 32'h2);
      bus(1'b1, 12'h000, 32'ha5);
      repeat (2) @(posedge clk);
      chk(pin_out, 8'h5a);
      bus(1'b1, 12'h00c, 32'h0);
      repeat (3) @(posedge clk);
      chk(pin_out, 8'ha5);
      chk(pin_oe, 8'hdf);
   endtask
   task automatic t_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk(pin_oe, 8'h00);
      rd(12'h004, 32'h0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      chk(pin_oe, 8'h00);
      rd(12'h004, 32'h0);
      chk(rerr, 32'h0);
      rd(12'h020, 32'h0);
      chk(rerr, 32'h1);
      t_in();
      t_periph();
      bus(1'b1, 12'h008, 32'hff);
      bus(1'b1, 12'h004, 32'h0f);
      bus(1'b1, 12'h000, 32'h05);
      repeat (2) @(posedge clk);
      chk(pull_on, 8'hf1);
      rd(12'h008, 32'hff);
      t_float();
      t_hold();
      t_reset();
      end_of_test();
   end
   initial begin
      #20000;
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
